// [shared/cisrd_regs.svh]
`ifndef CISRD_REGS_SVH
`define CISRD_REGS_SVH
`define CISRD_OFF_CTRL      12'h000
`define CISRD_OFF_STATUS    12'h004
`define CISRD_OFF_LEVEL_RG  12'h008
`define CISRD_OFF_LEVEL_BY  12'h00C
`define CISRD_OFF_COEF      12'h010
`define CISRD_OFF_TIMING    12'h014
`define CISRD_CTRL_LED_LSB  0
`define CISRD_CTRL_RUN_BIT  4
`define CISRD_CTRL_WHT_BIT  5
`define CISRD_CTRL_BLK_BIT  6
`define CISRD_CTRL_TRIM_BIT 7
`define CISRD_RST_CTRL      32'h0000_0000
`define CISRD_RST_LEVEL     8'h80
`define CISRD_RST_COEF      9'h0FF
`define CISRD_RST_TARGET    8'hC0
`define CISRD_RST_SHIFT_DIV 8'h04
`define CISRD_TRANSFER_LEN  8'h10
`define CISRD_FULL_SCALE    8'hFF
`endif

// [shared/cisrd_pkg.sv]
package cisrd_pkg;
  typedef enum logic [2:0] {
    CISRD_IDLE  = 3'b000,
    CISRD_XFER  = 3'b001,
    CISRD_SHIFT = 3'b010,
    CISRD_DONE  = 3'b011
  } cisrd_state_t;
  typedef enum logic [1:0] {
    CISRD_NORMAL = 2'b00,
    CISRD_WHITE  = 2'b01,
    CISRD_BLACK  = 2'b10
  } cisrd_mode_t;
  typedef logic [7:0] cisrd_pix_t;
endpackage : cisrd_pkg

// [rtl/cisrd_ram.sv]
`timescale 1ns/100ps
`default_nettype none
module cisrd_ram #(
  parameter int DEPTH = 7084,
  parameter int AW    = 13
) (
  // clock
  input  wire logic          clk,
  input  wire logic          ce,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [0:DEPTH-1];
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule : cisrd_ram
`default_nettype wire

// [rtl/cisrd_norm.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cisrd_regs.svh"
module cisrd_norm (
  // operands
  input  wire logic [7:0] sample,
  input  wire logic [7:0] black,
  input  wire logic [7:0] white,
  input  wire logic [8:0] coef,
  // result
  output logic      [7:0] result
);
  logic signed [9:0] num_s;
  logic signed [9:0] den_s;
  logic [16:0]       prod;
  logic [16:0]       quot;
  always_comb begin
    num_s  = $signed({2'b00, sample}) - $signed({2'b00, black});
    den_s  = $signed({2'b00, white}) - $signed({2'b00, black});
    prod   = 17'h0_0000;
    quot   = 17'h0_0000;
    result = 8'h00;
    if (den_s <= 10'sd0) begin
      result = `CISRD_FULL_SCALE;
    end else if (num_s > 10'sd0) begin
      prod = 17'(num_s[7:0]) * 17'(coef);
      quot = prod / 17'(den_s[7:0]);
      result = (quot > 17'h0_00FF) ? 8'hFF : quot[7:0];
    end
  end
endmodule : cisrd_norm
`default_nettype wire

// [rtl/cisrd_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cisrd_regs.svh"
module cisrd_top
  import cisrd_pkg::*;
#(
  parameter int PIX_PER_CHIP = 644,
  parameter int CHIPS_MAIN   = 3,
  parameter int CHIPS_LAST   = 2,
  parameter int CHANNELS     = 4,
  parameter int LINE_PIX     = 7084
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // exposure sources
  output logic             led_red_on,
  output logic             led_green_on,
  output logic             led_blue_on,
  output logic             led_yg_on,
  output logic      [7:0]  level_red,
  output logic      [7:0]  level_green,
  output logic      [7:0]  level_blue,
  output logic      [7:0]  level_yg,
  // sensor clocks
  output logic             charge_transfer_clock,
  output logic             sensor_shift_clock,
  output logic             output_reset_clock,
  // front end samples, one byte per channel
  input  wire logic [31:0] pixel_sample_bus,
  input  wire logic        sample_valid,
  // corrected stream
  output logic      [7:0]  pix_out,
  output logic             pix_out_valid,
  output logic      [12:0] pix_out_index,
  output logic             line_done
);
  import cisrd_pkg::*;
  localparam int CHAN_PIX = PIX_PER_CHIP * CHIPS_MAIN;
  localparam int LAST_PIX = PIX_PER_CHIP * CHIPS_LAST;

  cisrd_state_t state_q;
  cisrd_mode_t  mode_q;
  logic [31:0]  ctrl_q;
  logic [7:0]   lvl_r_q, lvl_b_q, lvl_y_q;
  logic [8:0]   coef_q;
  logic [7:0]   target_q;
  logic [7:0]   div_q;
  logic [7:0]   div_cnt_q;
  logic [7:0]   xfer_cnt_q;
  logic [10:0]  pos_q;
  logic [1:0]   lane_q;
  logic         busy_q;
  logic         wht_ok_q, blk_ok_q;
  logic [15:0]  sum_r_q, sum_b_q, sum_y_q;
  logic         sample_take;
  logic         apb_wr, apb_rd, addr_ok;
  logic [12:0]  addr_lane [0:3];
  logic [12:0]  wr_addr;
  logic [7:0]   cur_sample;
  logic [7:0]   blk_rd, wht_rd;
  logic [7:0]   norm_res;
  logic [7:0]   hold_sample_q;
  logic [12:0]  hold_addr_q;
  logic         hold_valid_q;
  logic         hold_last_q;

  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && penable && !pwrite;
  assign addr_ok = (paddr == `CISRD_OFF_CTRL) || (paddr == `CISRD_OFF_STATUS) ||
                   (paddr == `CISRD_OFF_LEVEL_RG) || (paddr == `CISRD_OFF_LEVEL_BY) ||
                   (paddr == `CISRD_OFF_COEF) || (paddr == `CISRD_OFF_TIMING);

  // lane positions of the four channels in the merged line
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign addr_lane[g] = 13'(g * CHAN_PIX) + 13'(pos_q);
    end
  endgenerate

  // the last channel carries fewer chips, so its samples stop early
  assign sample_take = (state_q == CISRD_SHIFT) && sample_valid && ce &&
                       !((lane_q == 2'(CHANNELS - 1)) && (pos_q >= 11'(LAST_PIX)));
  assign wr_addr     = addr_lane[lane_q];
  assign cur_sample  = pixel_sample_bus[8*lane_q +: 8];

  // apb register writes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_q   <= `CISRD_RST_CTRL;
      coef_q   <= `CISRD_RST_COEF;
      target_q <= `CISRD_RST_TARGET;
      div_q    <= `CISRD_RST_SHIFT_DIV;
    end else if (ce) begin
      if (apb_wr && paddr == `CISRD_OFF_CTRL && pstrb[0]) begin
        ctrl_q[7:0] <= pwdata[7:0];
      end else if (state_q == CISRD_DONE) begin
        ctrl_q[`CISRD_CTRL_RUN_BIT] <= 1'b0;
      end
      if (apb_wr && paddr == `CISRD_OFF_COEF) begin
        if (pstrb[0]) coef_q[7:0] <= pwdata[7:0];
        if (pstrb[1]) coef_q[8]   <= pwdata[8];
        if (pstrb[2]) target_q    <= pwdata[23:16];
      end
      // a divider below two would leave the shift clock flat
      if (apb_wr && paddr == `CISRD_OFF_TIMING && pstrb[0] && pwdata[7:0] > 8'h01) begin
        div_q <= pwdata[7:0];
      end
    end
  end

  // light levels: software writes or trim after captures, green is never moved
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lvl_r_q <= `CISRD_RST_LEVEL;
      lvl_b_q <= `CISRD_RST_LEVEL;
      lvl_y_q <= `CISRD_RST_LEVEL;
    end else if (ce) begin
      if (apb_wr && paddr == `CISRD_OFF_LEVEL_RG && pstrb[0]) begin
        lvl_r_q <= pwdata[7:0];
      end else if (apb_wr && paddr == `CISRD_OFF_LEVEL_BY) begin
        if (pstrb[0]) lvl_b_q <= pwdata[7:0];
        if (pstrb[1]) lvl_y_q <= pwdata[15:8];
      end else if (state_q == CISRD_DONE && mode_q == CISRD_WHITE &&
                   ctrl_q[`CISRD_CTRL_TRIM_BIT] && blk_ok_q) begin
        // mean of the captured white for each lane-colour band against the target
        if (sum_r_q[15:8] < target_q && lvl_r_q != 8'hFF) lvl_r_q <= lvl_r_q + 8'h01;
        if (sum_r_q[15:8] > target_q && lvl_r_q != 8'h00) lvl_r_q <= lvl_r_q - 8'h01;
        if (sum_b_q[15:8] < target_q && lvl_b_q != 8'hFF) lvl_b_q <= lvl_b_q + 8'h01;
        if (sum_b_q[15:8] > target_q && lvl_b_q != 8'h00) lvl_b_q <= lvl_b_q - 8'h01;
        if (sum_y_q[15:8] < target_q && lvl_y_q != 8'hFF) lvl_y_q <= lvl_y_q + 8'h01;
        if (sum_y_q[15:8] > target_q && lvl_y_q != 8'h00) lvl_y_q <= lvl_y_q - 8'h01;
      end
    end
  end

  // capture statistics: sum of the first 256 white samples on lanes 0..2
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sum_r_q <= 16'h0000;
      sum_b_q <= 16'h0000;
      sum_y_q <= 16'h0000;
    end else if (ce) begin
      if (state_q == CISRD_IDLE) begin
        sum_r_q <= 16'h0000;
        sum_b_q <= 16'h0000;
        sum_y_q <= 16'h0000;
      end else if (sample_take && mode_q == CISRD_WHITE && pos_q < 11'd256) begin
        if (lane_q == 2'd0) sum_r_q <= sum_r_q + 16'(cur_sample);
        if (lane_q == 2'd1) sum_b_q <= sum_b_q + 16'(cur_sample);
        if (lane_q == 2'd2) sum_y_q <= sum_y_q + 16'(cur_sample);
      end
    end
  end

  // line sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q    <= CISRD_IDLE;
      mode_q     <= CISRD_NORMAL;
      xfer_cnt_q <= 8'h00;
      pos_q      <= 11'h000;
      lane_q     <= 2'd0;
      busy_q     <= 1'b0;
      wht_ok_q   <= 1'b0;
      blk_ok_q   <= 1'b0;
    end else if (ce) begin
      case (state_q)
        CISRD_IDLE: begin
          busy_q <= 1'b0;
          if (ctrl_q[`CISRD_CTRL_RUN_BIT]) begin
            state_q    <= CISRD_XFER;
            busy_q     <= 1'b1;
            xfer_cnt_q <= `CISRD_TRANSFER_LEN;
            pos_q      <= 11'h000;
            lane_q     <= 2'd0;
            if (ctrl_q[`CISRD_CTRL_WHT_BIT]) mode_q <= CISRD_WHITE;
            else if (ctrl_q[`CISRD_CTRL_BLK_BIT]) mode_q <= CISRD_BLACK;
            else mode_q <= CISRD_NORMAL;
          end
        end
        CISRD_XFER: begin
          xfer_cnt_q <= xfer_cnt_q - 8'h01;
          if (xfer_cnt_q == 8'h01) state_q <= CISRD_SHIFT;
        end
        CISRD_SHIFT: begin
          if (sample_valid) begin
            if (lane_q == 2'(CHANNELS - 1)) begin
              lane_q <= 2'd0;
              if (pos_q == 11'(CHAN_PIX - 1)) state_q <= CISRD_DONE;
              else pos_q <= pos_q + 11'h001;
            end else begin
              lane_q <= lane_q + 2'd1;
            end
          end
        end
        CISRD_DONE: begin
          state_q <= CISRD_IDLE;
          if (mode_q == CISRD_WHITE) wht_ok_q <= 1'b1;
          if (mode_q == CISRD_BLACK) blk_ok_q <= 1'b1;
        end
        default: state_q <= CISRD_IDLE;
      endcase
    end
  end

  // sensor drive clocks, all chips share the one transfer clock
  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_cnt_q             <= 8'h00;
      charge_transfer_clock <= 1'b0;
      sensor_shift_clock    <= 1'b0;
      output_reset_clock    <= 1'b0;
    end else if (ce) begin
      charge_transfer_clock <= (state_q == CISRD_XFER);
      if (state_q == CISRD_SHIFT) begin
        div_cnt_q <= (div_cnt_q == div_q - 8'h01) ? 8'h00 : div_cnt_q + 8'h01;
        sensor_shift_clock <= (div_cnt_q < (div_q >> 1));
        output_reset_clock <= (div_cnt_q == 8'h00);
      end else begin
        div_cnt_q          <= 8'h00;
        sensor_shift_clock <= 1'b0;
        output_reset_clock <= 1'b0;
      end
    end
  end

  // exposure sources: forced on for white, forced off for black
  always_ff @(posedge clk) begin
    if (!resetn) begin
      led_red_on   <= 1'b0;
      led_green_on <= 1'b0;
      led_blue_on  <= 1'b0;
      led_yg_on    <= 1'b0;
      level_red    <= `CISRD_RST_LEVEL;
      level_green  <= `CISRD_RST_LEVEL;
      level_blue   <= `CISRD_RST_LEVEL;
      level_yg     <= `CISRD_RST_LEVEL;
    end else if (ce) begin
      if (busy_q && mode_q == CISRD_BLACK) begin
        {led_yg_on, led_blue_on, led_green_on, led_red_on} <= 4'h0;
      end else if (busy_q && mode_q == CISRD_WHITE) begin
        {led_yg_on, led_blue_on, led_green_on, led_red_on} <= 4'hF;
      end else begin
        {led_yg_on, led_blue_on, led_green_on, led_red_on} <= ctrl_q[3:0];
      end
      level_red   <= lvl_r_q;
      level_green <= `CISRD_RST_LEVEL;
      level_blue  <= lvl_b_q;
      level_yg    <= lvl_y_q;
    end
  end

  // reference memories
  cisrd_ram #(.DEPTH(LINE_PIX), .AW(13)) u_black (
    .clk   (clk),
    .ce    (ce),
    .we    (sample_take && mode_q == CISRD_BLACK),
    .waddr (wr_addr),
    .wdata (cur_sample),
    .raddr (wr_addr),
    .rdata (blk_rd)
  );
  cisrd_ram #(.DEPTH(LINE_PIX), .AW(13)) u_white (
    .clk   (clk),
    .ce    (ce),
    .we    (sample_take && mode_q == CISRD_WHITE),
    .waddr (wr_addr),
    .wdata (cur_sample),
    .raddr (wr_addr),
    .rdata (wht_rd)
  );

  // delay the sample one cycle to meet the reference read
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hold_sample_q <= 8'h00;
      hold_addr_q   <= 13'h0000;
      hold_valid_q  <= 1'b0;
      hold_last_q   <= 1'b0;
    end else if (ce) begin
      hold_sample_q <= cur_sample;
      hold_addr_q   <= wr_addr;
      hold_valid_q  <= sample_take && mode_q == CISRD_NORMAL;
      hold_last_q   <= (state_q == CISRD_SHIFT) && sample_valid && (lane_q == 2'(CHANNELS - 1)) &&
                       (pos_q == 11'(CHAN_PIX - 1));
    end
  end

  cisrd_norm u_norm (
    .sample (hold_sample_q),
    .black  (blk_rd),
    .white  (wht_rd),
    .coef   (coef_q),
    .result (norm_res)
  );

  // corrected output stream
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pix_out       <= 8'h00;
      pix_out_valid <= 1'b0;
      pix_out_index <= 13'h0000;
      line_done     <= 1'b0;
    end else if (ce) begin
      pix_out       <= norm_res;
      pix_out_valid <= hold_valid_q;
      pix_out_index <= hold_addr_q;
      line_done     <= hold_last_q;
    end
  end

  // apb read side, zero wait states, error on unmapped addresses
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `CISRD_OFF_CTRL:     prdata <= {24'h00_0000, ctrl_q[7:0]};
          `CISRD_OFF_STATUS:   prdata <= {20'h0_0000, 1'b0, state_q, 5'h00, blk_ok_q, wht_ok_q, busy_q};
          `CISRD_OFF_LEVEL_RG: prdata <= {16'h0000, `CISRD_RST_LEVEL, lvl_r_q};
          `CISRD_OFF_LEVEL_BY: prdata <= {16'h0000, lvl_y_q, lvl_b_q};
          `CISRD_OFF_COEF:     prdata <= {8'h00, target_q, 7'h00, coef_q};
          `CISRD_OFF_TIMING:   prdata <= {24'h00_0000, div_q};
          default:             prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : cisrd_top
`default_nettype wire

// [tb/cisrd_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module cisrd_properties #(
  parameter int LINE_PIX = 7084
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // sensor side
  input wire logic [7:0]  level_green,
  input wire logic        charge_transfer_clock,
  input wire logic        sensor_shift_clock,
  input wire logic        output_reset_clock,
  input wire logic        sample_valid,
  input wire logic        pix_out_valid,
  input wire logic [12:0] pix_out_index,
  input wire logic        line_done
);
  logic [7:0] hi_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // length of the current transfer clock pulse
  always_ff @(posedge clk) begin
    if (!resetn || !charge_transfer_clock) begin
      hi_q <= 8'h00;
    end else if (ce) begin
      hi_q <= hi_q + 8'h01;
    end
  end
  a_green_fixed: assert property (level_green == 8'h80)
    else $error("green level moved");
  a_xfer_width: assert property ($fell(charge_transfer_clock) |-> hi_q == 8'h10)
    else $error("transfer clock width wrong");
  a_xfer_alone: assert property (charge_transfer_clock |-> !sensor_shift_clock && !output_reset_clock)
    else $error("shift activity during transfer");
  a_reset_pulse: assert property (output_reset_clock |=> !output_reset_clock)
    else $error("reset clock wider than one cycle");
  a_index_range: assert property (pix_out_valid |-> pix_out_index < LINE_PIX)
    else $error("pixel index beyond line");
  a_out_latency: assert property (pix_out_valid |-> $past(sample_valid, 2))
    else $error("output without sample two cycles before");
  a_done_pulse: assert property (line_done |=> !line_done)
    else $error("line done wider than one cycle");
  a_apb_ready: assert property (ce && psel && !penable |=> pready)
    else $error("no zero wait answer");
  a_unmapped_err: assert property (pready && paddr > 12'h014 |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  cover property (pix_out_valid);
  cover property (line_done);
  cover property (pready && pslverr);
endmodule : cisrd_properties
bind cisrd_top cisrd_properties #(.LINE_PIX(LINE_PIX)) cisrd_properties_i (
  .clk, .resetn, .ce, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .level_green,
  .charge_transfer_clock, .sensor_shift_clock, .output_reset_clock, .sample_valid,
  .pix_out_valid, .pix_out_index, .line_done);
`default_nettype wire

// [tb/cisrd_sensor_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cisrd_sensor_model (
  // clock and reset
  input wire logic         clk,
  input wire logic         resetn,
  // sensor drive
  input wire logic         charge_transfer_clock,
  input wire logic         sensor_shift_clock,
  input wire logic [3:0]   leds_on,
  input wire logic         plate,
  // sample bus
  output logic      [31:0] pixel_sample_bus,
  output logic             sample_valid
);
  localparam int CH_PIX = 644 * 3;
  int          cnt;
  int          idx;
  logic        ssc_q;
  logic [7:0]  v;
  logic [31:0] word;
  function automatic logic [7:0] dark(input int i);
    return 8'h10 + 8'(i % 8);
  endfunction : dark
  function automatic logic [7:0] wht(input int i);
    return (i % 97 == 0) ? dark(i) : 8'hE0 - 8'(i % 16);
  endfunction : wht
  function automatic logic [7:0] doc(input int i);
    return 8'(i * 7);
  endfunction : doc
  // lanes take turns, each lane walks its own chips in time order
  assign idx = (cnt % 4) * CH_PIX + cnt / 4;
  assign v = !(|leds_on) ? dark(idx) : (plate ? wht(idx) : doc(idx));
  always_comb begin
    word = ~{4{v}};
    word[(cnt % 4) * 8 +: 8] = v;
  end
  initial begin
    pixel_sample_bus = 32'h0F0F_0F0F;
    sample_valid = 1'b0;
  end
  // one sample per shift clock rise, bus scrambles when idle
  always @(posedge clk) begin
    ssc_q <= sensor_shift_clock;
    sample_valid <= 1'b0;
    if (!resetn || charge_transfer_clock) begin
      cnt <= 0;
      pixel_sample_bus <= ~pixel_sample_bus;
    end else if (sensor_shift_clock && !ssc_q) begin
      sample_valid <= 1'b1;
      pixel_sample_bus <= word;
      cnt <= cnt + 1;
    end else begin
      pixel_sample_bus <= ~pixel_sample_bus;
    end
  end
endmodule : cisrd_sensor_model
`default_nettype wire

// [tb/cisrd_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module cisrd_top_tb;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        plate = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata, r, pixel_sample_bus;
  logic        pready, pslverr, e, sample_valid, pix_out_valid, line_done;
  logic        led_red_on, led_green_on, led_blue_on, led_yg_on;
  logic        charge_transfer_clock, sensor_shift_clock;
  logic [7:0]  level_red, level_green, level_blue, level_yg, pix_out;
  logic [12:0] pix_out_index;
  int          fail_count = 0;
  int          check_count = 0;
  int          pix_n = 0;
  int          cyc = 0;
  int          k = 255;
  always #5 clk = ~clk;
  cisrd_top cisrd_top_i (
    .clk, .resetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .led_red_on, .led_green_on, .led_blue_on, .led_yg_on,
    .level_red, .level_green, .level_blue, .level_yg, .charge_transfer_clock,
    .sensor_shift_clock, .output_reset_clock(), .pixel_sample_bus, .sample_valid,
    .pix_out, .pix_out_valid, .pix_out_index, .line_done);
  cisrd_sensor_model cisrd_sensor_model_i (
    .clk, .resetn, .charge_transfer_clock, .sensor_shift_clock,
    .leds_on({led_yg_on, led_blue_on, led_green_on, led_red_on}), .plate,
    .pixel_sample_bus, .sample_valid);
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk iff pready);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never reassigns psel in this time step
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0000_0000);
    check(n, r, x);
  endtask : rd
  task automatic wait_line;
    @(posedge clk iff line_done);
    @(posedge clk);
  endtask : wait_line
  function automatic logic [7:0] expect_pix(input int i);
    int s, b, w, q;
    s = cisrd_sensor_model_i.doc(i);
    b = cisrd_sensor_model_i.dark(i);
    w = cisrd_sensor_model_i.wht(i);
    if (w <= b) return 8'hFF;
    if (s <= b) return 8'h00;
    q = k * (s - b) / (w - b);
    return (q > 255) ? 8'hFF : 8'(q);
  endfunction : expect_pix
  always @(posedge clk) begin
    cyc++;
    // four lines at divider two take about 62000 cycles
    if (cyc == 90000) begin
      fail_count++;
      summarize();
    end
  end
  always @(posedge clk) begin
    if (pix_out_valid === 1'b1) begin
      pix_n++;
      check("pixel", {24'h0, pix_out}, {24'h0, expect_pix(int'(pix_out_index))});
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    check("levels", {level_red, level_green, level_blue, level_yg}, 32'h8080_8080);
    rd(12'h008, 32'h0000_8080, "level_rg");
    rd(12'h010, 32'h00C0_00FF, "coef");
    apb(1'b1, 12'h014, 32'h0000_0000);
    rd(12'h014, 32'h0000_0004, "timing");
    apb(1'b0, 12'h020, 32'h0000_0000);
    check("unmapped", {31'h0, e}, 32'h0000_0001);
    apb(1'b1, 12'h008, 32'h0000_1234);
    rd(12'h008, 32'h0000_8034, "green_held");
    apb(1'b1, 12'h008, 32'h0000_0080);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, 32'h1 << i);
      repeat (3) @(posedge clk);
      check("led", {28'h0, led_yg_on, led_blue_on, led_green_on, led_red_on}, 32'h1 << i);
    end
    // black reference line with the shift clock at divider two, the fastest allowed
    apb(1'b1, 12'h014, 32'h0000_0002);
    apb(1'b1, 12'h000, 32'h0000_005F);
    repeat (3) @(posedge clk);
    check("leds_black", {led_yg_on, led_blue_on, led_green_on, led_red_on}, 32'h0);
    wait_line();
    apb(1'b0, 12'h004, 32'h0000_0000);
    check("black_done", {31'h0, r[2]}, 32'h1);
    // white reference line with trim; a divider of one is refused
    apb(1'b1, 12'h014, 32'h0000_0001);
    rd(12'h014, 32'h0000_0002, "timing_floor");
    apb(1'b1, 12'h000, 32'h0000_00B0);
    repeat (3) @(posedge clk);
    check("leds_white", {led_yg_on, led_blue_on, led_green_on, led_red_on}, 32'hF);
    wait_line();
    apb(1'b0, 12'h004, 32'h0000_0000);
    check("white_done", {31'h0, r[1]}, 32'h1);
    check("trim", {level_red, level_green, level_blue, level_yg}, 32'h7F80_7F7F);
    check("no_output", pix_n, 32'h0);
    plate <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      k = (j == 0) ? 255 : 200;
      apb(1'b1, 12'h010, {8'h00, 8'hC0, 7'h00, 9'(k)});
      pix_n = 0;
      apb(1'b1, 12'h000, 32'h0000_001F);
      wait_line();
      check("line_count", pix_n, 32'd7084);
      rd(12'h000, 32'h0000_000F, "run_cleared");
    end
    // only the low byte lane is written: blue moves, yellow-green keeps its trimmed value
    pstrb <= 4'h1;
    apb(1'b1, 12'h00C, 32'h0000_5511);
    pstrb <= 4'hF;
    rd(12'h00C, 32'h0000_7F11, "strobe_lane");
    summarize();
  end
endmodule : cisrd_top_tb
`default_nettype wire
